// ===== rtl/loader_regs.svh
// Offsets, field positions, reset values and timing counts of the loader
`ifndef LOADER_REGS_SVH
`define LOADER_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define LDR_CTRL_OFS 8'h00
`define LDR_STATUS_OFS 8'h04
`define LDR_IRQ_STAT_OFS 8'h08
`define LDR_IRQ_MASK_OFS 8'h0C

// ==========================================================
// Field positions
`define LDR_CTRL_GO_BIT 0
`define LDR_CTRL_SWSEL_EN_BIT 1
`define LDR_CTRL_SWSEL_LSB 4
`define LDR_STAT_DONE_BIT 0
`define LDR_STAT_BUSY_BIT 1
`define LDR_STAT_IDX_LSB 8
`define LDR_STAT_SEL_LSB 16
`define LDR_IRQ_DONE_BIT 0
`define LDR_IRQ_RESTART_BIT 1
`define LDR_ENTRY_WAIT_BIT 32
`define LDR_DIV_LSB 5
`define LDR_DIV_MSB 15

// Select bits per connector
`define LDR_SEL_A_BIT 3
`define LDR_SEL_D_BIT 2
`define LDR_SEL_B_BIT 1
`define LDR_SEL_C_BIT 0

// ==========================================================
// Reset values
`define LDR_CTRL_RST 8'h00
`define LDR_IRQ_RST 2'h0

// ==========================================================
// Timing
`define LDR_CLK_MHZ 20
`define LDR_SCLK_HALF_NS 100
`define LDR_SCLK_HALF_CYC \
  (((`LDR_SCLK_HALF_NS * `LDR_CLK_MHZ) + 999) / 1000)
`define LDR_NUM_ENTRIES 30

`endif

// ===== rtl/loader_pkg.sv
// Types shared by the configuration loader and its serial shifter
package loader_pkg;

  typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_LATCH} shift_state_e;

  typedef enum logic [2:0] {
    LD_IDLE, LD_FETCH, LD_WAIT, LD_SEND, LD_DONE
  } load_state_e;

  typedef logic [32:0] table_entry_t;

endpackage

// ===== rtl/spi_word_shifter.sv
// Serial shifter: one 32-bit word out MSB first, then a latch pulse
`timescale 1ns/100ps
`include "loader_regs.svh"

module spi_word_shifter #(
  parameter int HALF_CYC = `LDR_SCLK_HALF_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic abort,
  input wire logic start,
  input wire logic [31:0] word,
  output logic done,
  // Serial link
  output logic sclk,
  output logic sdata,
  output logic latch
);

  initial begin
    if (HALF_CYC < 1 || HALF_CYC > 255) begin
      $error("HALF_CYC out of range");
    end
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  loader_pkg::shift_state_e state_q;
  logic [7:0] div_q;
  logic [31:0] shreg_q;
  logic [4:0] bit_q;
  logic tick;

  assign tick = (div_q == HALF_LAST);
  assign sdata = shreg_q[31];

  // ==========================================================
  // Divider: half period of the serial clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 8'h00;
    end else if (state_q == loader_pkg::SH_IDLE || tick || abort) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= loader_pkg::SH_IDLE;
      shreg_q <= 32'h0000_0000;
      bit_q <= 5'h00;
      sclk <= 1'b0;
      latch <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state_q <= loader_pkg::SH_IDLE;
        sclk <= 1'b0;
        latch <= 1'b0;
      end else begin
        unique case (state_q)
          loader_pkg::SH_IDLE: begin
            if (start) begin
              shreg_q <= word;
              bit_q <= 5'h1F;
              state_q <= loader_pkg::SH_LOW;
            end
          end
          loader_pkg::SH_LOW: begin
            if (tick) begin
              sclk <= 1'b1;
              state_q <= loader_pkg::SH_HIGH;
            end
          end
          loader_pkg::SH_HIGH: begin
            if (tick) begin
              sclk <= 1'b0;
              if (bit_q == 5'h00) begin
                latch <= 1'b1;
                state_q <= loader_pkg::SH_LATCH;
              end else begin
                shreg_q <= {shreg_q[30:0], 1'b0};
                bit_q <= bit_q - 5'h01;
                state_q <= loader_pkg::SH_LOW;
              end
            end
          end
          loader_pkg::SH_LATCH: begin
            if (tick) begin
              latch <= 1'b0;
              done <= 1'b1;
              state_q <= loader_pkg::SH_IDLE;
            end
          end
        endcase
      end
    end
  end

endmodule

// ===== rtl/pll_spi_config_loader.sv
// Loader that walks a fixed table into an external clock synthesizer
`timescale 1ns/100ps
`include "loader_regs.svh"

module pll_spi_config_loader #(
  parameter int WAIT_SHIFT = 0,
  parameter int HALF_CYC = `LDR_SCLK_HALF_CYC
) (
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // User side
  input wire logic config_reset_n,
  input wire logic [3:0] freq_combo_select,
  output logic config_done,
  output logic irq,
  // Synthesizer link
  output logic synth_serial_clock,
  output logic synth_serial_data,
  output logic synth_latch_strobe
);

  initial begin
    if (WAIT_SHIFT < 0 || WAIT_SHIFT > 31) begin
      $error("WAIT_SHIFT out of range");
    end
  end

  // ==========================================================
  // Table of entries
  // words replaceable here
  function automatic loader_pkg::table_entry_t table_entry(
    input logic [4:0] idx, input logic [3:0] sel);
    loader_pkg::table_entry_t e;
    logic hi;
    e = 33'h0_0000_0000;
    hi = 1'b0;
    unique case (idx)
      5'd0, 5'd2, 5'd4, 5'd29: e = 33'h1_0000_61A8;
      5'd1: e = 33'h0_8016_0200;
      5'd3: e = 33'h0_2014_0080;
      5'd5: e = 33'h0_1014_0081;
      5'd6: e = 33'h0_A014_0082;
      5'd7: e = 33'h0_0014_0083;
      5'd8: e = 33'h0_0014_0084;
      5'd9: e = 33'h0_8014_0085;
      5'd10: e = 33'h0_0114_0006;
      5'd11: e = 33'h0_0111_0007;
      5'd12: e = 33'h0_0001_0008;
      5'd13: e = 33'h0_5555_5549;
      5'd14: e = 33'h0_9002_410A;
      5'd15: e = 33'h0_3401_100B;
      5'd16: e = 33'h0_130C_006C;
      5'd17: e = 33'h0_3B02_820D;
      5'd18: e = 33'h0_0200_000E;
      5'd19: e = 33'h0_8000_800F;
      5'd20: e = 33'h0_C155_0410;
      5'd21: e = 33'h0_0000_00D8;
      5'd22: e = 33'h0_02C9_C419;
      5'd23: e = 33'h0_8FA8_001A;
      5'd24: e = 33'h0_1000_0F3B;
      5'd25: e = 33'h0_0080_031C;
      5'd26: e = 33'h0_0800_227D;
      5'd27: e = 33'h0_0300_227E;
      5'd28: e = 33'h0_001F_001F;
      default: e = 33'h1_0000_0001;
    endcase
    unique case (idx)
      5'd3: hi = sel[`LDR_SEL_A_BIT];
      5'd5: hi = sel[`LDR_SEL_B_BIT];
      5'd7: hi = sel[`LDR_SEL_C_BIT];
      5'd8: hi = sel[`LDR_SEL_D_BIT];
      default: hi = 1'b0;
    endcase
    // Halving the divider doubles the output rate
    if (hi) begin
      e[`LDR_DIV_MSB:`LDR_DIV_LSB] = e[`LDR_DIV_MSB:`LDR_DIV_LSB] >> 1;
    end
    return e;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic rst_s1_q, rst_s2_q, rst_prev_q;
  logic [3:0] sel_s1_q, sel_s2_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
      rst_prev_q <= 1'b0;
      sel_s1_q <= 4'h0;
      sel_s2_q <= 4'h0;
    end else begin
      rst_s1_q <= config_reset_n;
      rst_s2_q <= rst_s1_q;
      rst_prev_q <= rst_s2_q;
      sel_s1_q <= freq_combo_select;
      sel_s2_q <= sel_s1_q;
    end
  end

  // ==========================================================
  // Bus slave
  logic [7:0] ctrl_q;
  logic [1:0] irq_stat_q, irq_mask_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic addr_ok;
  logic go_pulse;
  logic [1:0] events;
  loader_pkg::load_state_e state_q;
  logic [4:0] idx_q;
  logic [3:0] sel_q;
  logic [31:0] status_word;

  assign addr_ok = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign go_pulse = wr_pend_q && (wr_addr_q == `LDR_CTRL_OFS) &&
                    hwdata[`LDR_CTRL_GO_BIT];
  assign irq = |(irq_stat_q & irq_mask_q);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`LDR_STAT_DONE_BIT] = config_done;
    status_word[`LDR_STAT_BUSY_BIT] = (state_q != loader_pkg::LD_IDLE) &&
                                      (state_q != loader_pkg::LD_DONE);
    status_word[`LDR_STAT_IDX_LSB +: 5] = idx_q;
    status_word[`LDR_STAT_SEL_LSB +: 4] = sel_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
      hrdata <= 32'h0000_0000;
      if (addr_ok && !hwrite) begin
        unique case (haddr[7:0])
          `LDR_CTRL_OFS: hrdata <= {24'h00_0000, ctrl_q};
          `LDR_STATUS_OFS: hrdata <= status_word;
          `LDR_IRQ_STAT_OFS: hrdata <= {30'h0000_0000, irq_stat_q};
          `LDR_IRQ_MASK_OFS: hrdata <= {30'h0000_0000, irq_mask_q};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Go bit is a strobe and never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `LDR_CTRL_RST;
      irq_mask_q <= `LDR_IRQ_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `LDR_CTRL_OFS) begin
        ctrl_q <= {hwdata[7:4], 2'h0, hwdata[1], 1'b0};
      end
      if (wr_addr_q == `LDR_IRQ_MASK_OFS) begin
        irq_mask_q <= hwdata[1:0];
      end
    end
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= `LDR_IRQ_RST;
    end else if (wr_pend_q && wr_addr_q == `LDR_IRQ_STAT_OFS) begin
      irq_stat_q <= (irq_stat_q & ~hwdata[1:0]) | events;
    end else begin
      irq_stat_q <= irq_stat_q | events;
    end
  end

  // ==========================================================
  // Table walker
  logic restart;
  logic sh_start, sh_done;
  logic [31:0] wait_q;
  loader_pkg::table_entry_t cur;

  assign restart = (rst_s2_q && !rst_prev_q) || (go_pulse && rst_s2_q);
  assign cur = table_entry(idx_q, sel_q);
  assign sh_start = (state_q == loader_pkg::LD_FETCH) &&
                    (idx_q < 5'(`LDR_NUM_ENTRIES)) &&
                    !cur[`LDR_ENTRY_WAIT_BIT];
  assign events[`LDR_IRQ_DONE_BIT] = (state_q == loader_pkg::LD_FETCH) &&
                                     (idx_q == 5'(`LDR_NUM_ENTRIES));
  assign events[`LDR_IRQ_RESTART_BIT] = restart;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= loader_pkg::LD_IDLE;
      idx_q <= 5'h00;
      sel_q <= 4'h0;
      wait_q <= 32'h0000_0000;
      config_done <= 1'b0;
    end else if (!rst_s2_q) begin
      state_q <= loader_pkg::LD_IDLE;
      idx_q <= 5'h00;
      config_done <= 1'b0;
    end else if (restart) begin
      state_q <= loader_pkg::LD_FETCH;
      idx_q <= 5'h00;
      sel_q <= ctrl_q[`LDR_CTRL_SWSEL_EN_BIT] ?
               ctrl_q[`LDR_CTRL_SWSEL_LSB +: 4] : sel_s2_q;
      config_done <= 1'b0;
    end else begin
      unique case (state_q)
        loader_pkg::LD_IDLE: begin
        end
        loader_pkg::LD_FETCH: begin
          if (idx_q == 5'(`LDR_NUM_ENTRIES)) begin
            state_q <= loader_pkg::LD_DONE;
          end else if (cur[`LDR_ENTRY_WAIT_BIT]) begin
            wait_q <= cur[31:0] >> WAIT_SHIFT;
            state_q <= loader_pkg::LD_WAIT;
          end else begin
            state_q <= loader_pkg::LD_SEND;
          end
        end
        loader_pkg::LD_WAIT: begin
          if (wait_q <= 32'h0000_0001) begin
            idx_q <= idx_q + 5'h01;
            state_q <= loader_pkg::LD_FETCH;
          end else begin
            wait_q <= wait_q - 32'h0000_0001;
          end
        end
        loader_pkg::LD_SEND: begin
          if (sh_done) begin
            idx_q <= idx_q + 5'h01;
            state_q <= loader_pkg::LD_FETCH;
          end
        end
        loader_pkg::LD_DONE: begin
          config_done <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Serial link
  // output-only divided link
  spi_word_shifter #(
    .HALF_CYC(HALF_CYC)
  ) shifter (
    .hclk(hclk),
    .hresetn(hresetn),
    .abort(!rst_s2_q || restart),
    .start(sh_start),
    .word(cur[31:0]),
    .done(sh_done),
    .sclk(synth_serial_clock),
    .sdata(synth_serial_data),
    .latch(synth_latch_strobe)
  );

endmodule

// ===== testbench/synth_model.sv
// Behavioural synthesizer: collects each latched word
`timescale 1ns/100ps
module synth_model (
  // Serial link
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latch,
  // Bench control
  input wire logic clr
);
  logic [31:0] sh_q = 32'h0;
  int nbits = 0;
  int bad_len = 0;
  logic [31:0] words[$];
  // ========
  // Capture
  // MSB first
  always @(posedge sclk) begin
    sh_q = {sh_q[30:0], sdata};
    nbits++;
  end
  always @(posedge latch) begin
    if (nbits != 32) begin
      bad_len++;
    end
    words.push_back(sh_q);
    nbits = 0;
  end
  // Bench drops any partial word of an aborted walk
  always @(posedge clr) begin
    words.delete();
    nbits = 0;
  end
endmodule

// ===== testbench/pll_spi_config_loader_props.sv
// Port checks for the configuration loader
`timescale 1ns/100ps
module loader_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // User side
  input wire logic config_reset_n,
  input wire logic config_done,
  // Link
  input wire logic synth_serial_clock,
  input wire logic synth_serial_data,
  input wire logic synth_latch_strobe
);
  // ========
  // Properties (widths assume a half period of 2)
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rst_idle;
    (!config_reset_n)[*5] |-> !config_done && !synth_latch_strobe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy in reset");
  property p_done_quiet;
    config_done |-> !synth_serial_clock && !synth_latch_strobe;
  endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("link active");
  property p_sclk_high;
    disable iff (!hresetn || !config_reset_n)
    $rose(synth_serial_clock) |=> synth_serial_clock ##1 !synth_serial_clock;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("sclk width");
  property p_data_hold;
    disable iff (!hresetn || !config_reset_n)
    $rose(synth_serial_clock) |=> $stable(synth_serial_data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_latch_gap;
    synth_latch_strobe |-> !synth_serial_clock;
  endproperty
  a_latch_gap: assert property (p_latch_gap) else $error("latch with sclk");
  property p_latch_width;
    disable iff (!hresetn || !config_reset_n)
    $rose(synth_latch_strobe) |=> synth_latch_strobe ##1 !synth_latch_strobe;
  endproperty
  a_latch_width: assert property (p_latch_width) else $error("latch width");
  property p_wait_first;
    disable iff (!hresetn || !config_reset_n)
    $rose(config_reset_n) |=> (!synth_serial_clock)[*8];
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait");
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not okay"); // OKAY
  c_done: cover property ($rose(config_done));
  c_latch: cover property ($rose(synth_latch_strobe));
  c_restart: cover property ($rose(config_reset_n));
endmodule

bind pll_spi_config_loader loader_props u_props (
  .hclk(hclk),
  .hresetn(hresetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .config_reset_n(config_reset_n),
  .config_done(config_done),
  .synth_serial_clock(synth_serial_clock),
  .synth_serial_data(synth_serial_data),
  .synth_latch_strobe(synth_latch_strobe)
);

// ===== testbench/pll_spi_config_loader_tb.sv
// Self-checking bench for the configuration loader
`timescale 1ns/100ps
module pll_spi_config_loader_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic config_reset_n = 1'b0;
  logic [3:0] freq_combo_select = 4'h0;
  logic config_done;
  logic irq;
  logic sclk;
  logic sdata;
  logic latch;
  logic clr = 1'b0;
  logic [31:0] rd;
  int mismatches = 0;
  int n_compared = 0;

  always #25 hclk = ~hclk;

  // Wait entries shortened to keep the run brief
  pll_spi_config_loader #(.WAIT_SHIFT(8), .HALF_CYC(2)) u_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hready(hreadyout),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .config_reset_n(config_reset_n),
    .freq_combo_select(freq_combo_select),
    .config_done(config_done),
    .irq(irq),
    .synth_serial_clock(sclk),
    .synth_serial_data(sdata),
    .synth_latch_strobe(latch)
  );
  synth_model u_synth (.sclk(sclk), .sdata(sdata), .latch(latch), .clr(clr));

  // ========
  // Helpers
  task automatic conclude;
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    mismatches++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e, string m);
    n_compared++;
    if (g !== e) begin
      fail(m);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail("bus hang");
      conclude();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] w);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (config_done !== 1'b1 && n < 20000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 20000) begin
      fail("walk hang");
      conclude();
    end
  endtask
  // High rate halves the divider field in bits 15:5
  function automatic logic [31:0] halve(input logic [31:0] w, input logic hi);
    halve = hi ? {w[31:16], 1'b0, w[15:6], w[4:0]} : w;
  endfunction
  task automatic restart(input logic [3:0] sel);
    config_reset_n <= 1'b0;
    freq_combo_select <= sel;
    repeat (5) @(posedge hclk);
    check({31'h0, config_done}, 32'h0, "done in reset");
    clr <= 1'b1;
    config_reset_n <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (3) @(posedge hclk);
    check({31'h0, config_done}, 32'h0, "done early");
  endtask
  task automatic check_words(input logic [3:0] sel);
    check(32'(u_synth.words.size()), 32'd26, "word count");
    check(32'(u_synth.bad_len), 32'h0, "bits per word");
    check(u_synth.words[0], 32'h80160200, "first word");
    check(u_synth.words[1], halve(32'h20140080, sel[3]), "conn a");
    check(u_synth.words[2], halve(32'h10140081, sel[1]), "conn b");
    check(u_synth.words[4], halve(32'h00140083, sel[0]), "conn c");
    check(u_synth.words[5], halve(32'h00140084, sel[2]), "conn d");
    check(u_synth.words[25], 32'h001F001F, "last word");
  endtask

  // ========
  // Scenarios
  task automatic t_walk(input logic [3:0] sel);
    restart(sel);
    wait_done();
    check_words(sel);
    ahb(1'b0, 8'h04, 32'h0);
    check({rd[19:16], rd[12:8], rd[1:0]}, {21'h0, sel, 5'd30, 2'b01},
          "status");
  endtask
  task automatic t_abort;
    restart(4'h0);
    repeat (700) @(posedge hclk);
    restart(4'h8);
    wait_done();
    check_words(4'h8);
  endtask
  task automatic t_regs;
    ahb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0, "ctrl reset");
    ahb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0, "unmapped read");
    ahb(1'b0, 8'h08, 32'h0);
    check({30'h0, rd[1:0]}, 32'h3, "done and restart events");
    check({31'h0, irq}, 32'h0, "irq masked");
    ahb(1'b1, 8'h0C, 32'h1);
    // Mask lands at the closing edge; irq follows it with no register in between
    @(posedge hclk);
    check({31'h0, irq}, 32'h1, "irq raised");
    ahb(1'b1, 8'h08, 32'h3);
    ahb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0, "w1c clear");
    check({31'h0, irq}, 32'h0, "irq cleared");
  endtask
  task automatic t_sw;
    clr <= 1'b1;
    // Go takes the stored select, so store it first; pin stays 8
    ahb(1'b1, 8'h00, 32'h42);
    ahb(1'b1, 8'h00, 32'h43);
    clr <= 1'b0;
    repeat (4) @(posedge hclk);
    check({31'h0, config_done}, 32'h0, "go restarts");
    wait_done();
    check_words(4'h4);
    check({31'h0, irq}, 32'h1, "irq on done");
    ahb(1'b1, 8'h00, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_walk(4'h0);
    t_walk(4'h1);
    t_walk(4'h2);
    t_abort();
    t_regs();
    t_sw();
    conclude();
  end
endmodule
